// ### rtl/ltfs_map.svh
// constants for the letters tape feed-out sequencer
`ifndef LTFS_MAP_SVH
`define LTFS_MAP_SVH

// =====================================================
// clock and timing
`define LTFS_CLK_PERIOD_NS 50
`define LTFS_SLIDE_CLEAR_NS 1000
`define LTFS_SLIDE_CLEAR_CYCLES ((`LTFS_SLIDE_CLEAR_NS + `LTFS_CLK_PERIOD_NS - 1) / `LTFS_CLK_PERIOD_NS)

// =====================================================
// tape geometry, lengths in thousandths of an inch
`define LTFS_ROW_MILS 100
`define LTFS_STEP_MILS 600
`define LTFS_MAX_MILS 18000
`define LTFS_ROWS_PER_STEP (`LTFS_STEP_MILS / `LTFS_ROW_MILS)
`define LTFS_MAX_STEPS (`LTFS_MAX_MILS / `LTFS_STEP_MILS)

// =====================================================
// metering
`define LTFS_STAGE1_W 3
`define LTFS_STAGE2_W 5
`define LTFS_TRIP_STEPS 5'h02

// =====================================================
// punch data
`define LTFS_CODE_W 5
`define LTFS_LETTERS_CODE 5'h1F
`define LTFS_FIFO_DEPTH 8

`endif

// ### rtl/ltfs_pkg.sv
// types for the letters tape feed-out sequencer
package ltfs_pkg;

  // =====================================================
  // sequencer states, one-hot
  typedef enum logic [2:0]
  {
    SEQ_IDLE = 3'b001,
    SEQ_FEED = 3'b010,
    SEQ_RECV = 3'b100
  } ltfs_seq_type;

  // =====================================================
  // punch cycle states, one-hot
  typedef enum logic [3:0]
  {
    PUN_IDLE = 4'b0001,
    PUN_RELEASE = 4'b0010,
    PUN_STRIKE = 4'b0100,
    PUN_CLEAR = 4'b1000
  } ltfs_pun_type;

  // =====================================================
  // one tape row: feed hole plus five code holes
  typedef struct packed
  {
    logic feed_hole;
    logic [4:0] code;
  } ltfs_row_type;

endpackage

// ### rtl/ltfs_fifo.sv
// character buffer between selector and punch
`timescale 1ns/100ps
`default_nettype none

module ltfs_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 8
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic do_write;
  logic do_read;
  logic [CW-1:0] next_count;

  assign do_write = in_valid_i & in_ready_o;
  assign do_read = out_ready_i & out_valid_o;
  assign out_data_o = mem[rd_ptr];

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  always_comb
  begin
    next_count = count;
    if (do_write && !do_read)
      next_count = CW'(count + 1'b1);
    else if (do_read && !do_write)
      next_count = CW'(count - 1'b1);
  end

  // =====================================================
  // storage
  always_ff @(posedge clock_i)
  begin
    if (do_write)
      mem[wr_ptr] <= in_data_i;
  end

  // =====================================================
  // pointers and flags; flags are flops so ready is clean
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready_o <= 1'b0;
      out_valid_o <= 1'b0;
    end
    else
    begin
      if (do_write)
        wr_ptr <= bump(wr_ptr);
      if (do_read)
        rd_ptr <= bump(rd_ptr);
      count <= next_count;
      in_ready_o <= (next_count != CW'(DEPTH));
      out_valid_o <= (next_count != '0);
    end
  end

endmodule // ltfs_fifo

`default_nettype wire

// ### rtl/ltfs_top.sv
// letters tape feed-out sequencer for a receive-only tape punch
`timescale 1ns/100ps
`default_nettype none
`include "ltfs_map.svh"

module ltfs_top #(
  parameter int FIFO_DEPTH = `LTFS_FIFO_DEPTH,
  parameter int SLIDE_CLEAR_CYCLES = `LTFS_SLIDE_CLEAR_CYCLES
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic shaft_index_i,
  input wire logic feed_request_i,
  input wire logic line_active_i,
  input wire logic [`LTFS_STAGE2_W-1:0] feed_length_i,
  input wire logic char_valid_i,
  input wire logic [`LTFS_CODE_W-1:0] char_code_i,
  output logic char_ready_o,
  output logic punch_strobe_o,
  output var ltfs_pkg::ltfs_row_type punch_row_o,
  output logic tape_step_o,
  output logic slide_hold_o,
  output logic feed_busy_o,
  output logic recv_busy_o,
  output logic feed_lockout_o
);

  // =====================================================
  // declarations
  logic shaft_meta;
  logic shaft_sync;
  logic shaft_last;
  logic req_meta;
  logic req_sync;
  logic line_meta;
  logic line_sync;
  logic [`LTFS_STAGE2_W-1:0] len_meta;
  logic [`LTFS_STAGE2_W-1:0] len_sync;
  logic cycle_en;
  ltfs_pkg::ltfs_seq_type seq;
  ltfs_pkg::ltfs_pun_type pun;
  logic arm_pending;
  logic lockout;
  logic accept;
  logic [`LTFS_STAGE1_W-1:0] stage1;
  logic [`LTFS_STAGE2_W-1:0] stage2;
  logic [`LTFS_STAGE2_W-1:0] length_cfg;
  logic trip_enable;
  logic meter_done;
  logic letters_go;
  logic char_go;
  logic pun_free;
  logic row_is_letters;
  logic [7:0] clear_cnt;
  logic fifo_valid;
  logic [`LTFS_CODE_W-1:0] fifo_code;
  logic fifo_ready;

  localparam logic [`LTFS_STAGE1_W-1:0] STAGE1_LAST = `LTFS_STAGE1_W'(`LTFS_ROWS_PER_STEP - 1);
  localparam logic [`LTFS_STAGE2_W-1:0] MAX_STEPS = `LTFS_STAGE2_W'(`LTFS_MAX_STEPS);
  localparam logic [7:0] CLEAR_LAST = 8'((SLIDE_CLEAR_CYCLES > 1) ? SLIDE_CLEAR_CYCLES - 1 : 0);

  // length limited to the longest run the tape path allows
  function automatic logic [`LTFS_STAGE2_W-1:0] clamp_steps(input logic [`LTFS_STAGE2_W-1:0] steps);
    clamp_steps = (steps > MAX_STEPS) ? MAX_STEPS : steps;
  endfunction

  // =====================================================
  // pin synchronisers
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      shaft_meta <= 1'b0;
      shaft_sync <= 1'b0;
      shaft_last <= 1'b0;
    end
    else
    begin
      shaft_meta <= shaft_index_i;
      shaft_sync <= shaft_meta;
      shaft_last <= shaft_sync;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
      line_meta <= 1'b0;
      line_sync <= 1'b0;
      len_meta <= '0;
      len_sync <= '0;
    end
    else
    begin
      req_meta <= feed_request_i;
      req_sync <= req_meta;
      line_meta <= line_active_i;
      line_sync <= line_meta;
      len_meta <= feed_length_i;
      len_sync <= len_meta;
    end
  end

  // one strobe per main-shaft revolution
  assign cycle_en = shaft_sync & ~shaft_last;

  // =====================================================
  // request latching and non-repeat lockout
  // acceptance only from a quiet punch; the far end is trusted for the idle delay
  assign accept = cycle_en & req_sync & ~arm_pending & ~lockout
                & (seq == ltfs_pkg::SEQ_IDLE) & ~line_sync;

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      arm_pending <= 1'b0;
      lockout <= 1'b0;
    end
    else if (!req_sync)
    begin
      arm_pending <= 1'b0;
      lockout <= 1'b0;
    end
    else if (accept)
    begin
      arm_pending <= 1'b1;
    end
    else if (cycle_en && arm_pending)
    begin
      arm_pending <= 1'b0;
      lockout <= 1'b1;
    end
  end

  // =====================================================
  // two-stage length meter
  // length captured once per run so a strap change cannot tear the word mid-run
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      length_cfg <= '0;
    else if (accept)
      length_cfg <= clamp_steps(len_sync);
  end
  assign trip_enable = (stage2 >= `LTFS_TRIP_STEPS);
  assign meter_done = (stage2 >= length_cfg);

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      stage1 <= '0;
      stage2 <= '0;
    end
    else if (seq != ltfs_pkg::SEQ_FEED)
    begin
      stage1 <= '0;
      stage2 <= '0;
    end
    else if (cycle_en && !meter_done)
    begin
      if (stage1 == STAGE1_LAST)
      begin
        stage1 <= '0;
        stage2 <= `LTFS_STAGE2_W'(stage2 + 1'b1);
      end
      else
      begin
        stage1 <= `LTFS_STAGE1_W'(stage1 + 1'b1);
      end
    end
  end

  // =====================================================
  // sequencer
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      seq <= ltfs_pkg::SEQ_IDLE;
    else
    begin
      case (seq)
        ltfs_pkg::SEQ_IDLE:
        begin
          if (line_sync)
            seq <= ltfs_pkg::SEQ_RECV;
          else if (accept)
            seq <= ltfs_pkg::SEQ_FEED;
        end
        ltfs_pkg::SEQ_FEED:
        begin
          if (line_sync)
            seq <= ltfs_pkg::SEQ_RECV;
          else if (cycle_en && meter_done)
            seq <= ltfs_pkg::SEQ_IDLE;
        end
        ltfs_pkg::SEQ_RECV:
        begin
          // stay until the last buffered character is on the tape
          if (!line_sync && !fifo_valid && pun_free)
            seq <= ltfs_pkg::SEQ_IDLE;
        end
        default:
          seq <= ltfs_pkg::SEQ_IDLE;
      endcase
    end
  end

  // =====================================================
  // punch cycle start
  assign pun_free = (pun == ltfs_pkg::PUN_IDLE);
  // line characters win over letters so a message is never mixed
  assign char_go = cycle_en & pun_free & fifo_valid;
  assign letters_go = cycle_en & pun_free & ~fifo_valid & ~line_sync
                    & (seq == ltfs_pkg::SEQ_FEED) & trip_enable & ~meter_done;
  assign fifo_ready = char_go;

  ltfs_fifo #(
    .WIDTH(`LTFS_CODE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(char_valid_i),
    .in_data_i(char_code_i),
    .in_ready_o(char_ready_o),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_code),
    .out_ready_i(fifo_ready)
  );

  // =====================================================
  // punch cycle: release hold, strike, hold until slides clear
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      pun <= ltfs_pkg::PUN_IDLE;
    else
    begin
      case (pun)
        ltfs_pkg::PUN_IDLE:
        begin
          if (char_go || letters_go)
            pun <= ltfs_pkg::PUN_RELEASE;
        end
        ltfs_pkg::PUN_RELEASE:
        begin
          // a letters row not yet struck is dropped when the line wakes
          if (row_is_letters && line_sync)
            pun <= ltfs_pkg::PUN_IDLE;
          else
            pun <= ltfs_pkg::PUN_STRIKE;
        end
        ltfs_pkg::PUN_STRIKE:
          pun <= ltfs_pkg::PUN_CLEAR;
        ltfs_pkg::PUN_CLEAR:
        begin
          if (clear_cnt >= CLEAR_LAST)
            pun <= ltfs_pkg::PUN_IDLE;
        end
        default:
          pun <= ltfs_pkg::PUN_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      clear_cnt <= '0;
    else if (pun == ltfs_pkg::PUN_CLEAR)
      clear_cnt <= 8'(clear_cnt + 1'b1);
    else
      clear_cnt <= '0;
  end

  // =====================================================
  // row latch
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      punch_row_o <= '0;
      row_is_letters <= 1'b0;
    end
    else if (char_go)
    begin
      punch_row_o.feed_hole <= 1'b1;
      punch_row_o.code <= fifo_code;
      row_is_letters <= 1'b0;
    end
    else if (letters_go)
    begin
      punch_row_o.feed_hole <= 1'b1;
      punch_row_o.code <= `LTFS_LETTERS_CODE;
      row_is_letters <= 1'b1;
    end
  end

  // =====================================================
  // punch outputs
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      punch_strobe_o <= 1'b0;
      tape_step_o <= 1'b0;
      slide_hold_o <= 1'b1;
    end
    else
    begin
      // strike and step share one pulse so holes and advance stay aligned
      punch_strobe_o <= (pun == ltfs_pkg::PUN_RELEASE) && !(row_is_letters && line_sync);
      tape_step_o <= (pun == ltfs_pkg::PUN_RELEASE) && !(row_is_letters && line_sync);
      // hold drops one clock ahead of the strike
      slide_hold_o <= !(((pun == ltfs_pkg::PUN_IDLE) && (char_go || letters_go))
                      || ((pun == ltfs_pkg::PUN_RELEASE) && !(row_is_letters && line_sync)));
    end
  end

  // =====================================================
  // status outputs
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      feed_busy_o <= 1'b0;
      recv_busy_o <= 1'b0;
      feed_lockout_o <= 1'b0;
    end
    else
    begin
      feed_busy_o <= (seq == ltfs_pkg::SEQ_FEED);
      recv_busy_o <= (seq == ltfs_pkg::SEQ_RECV);
      feed_lockout_o <= lockout;
    end
  end

endmodule // ltfs_top

`default_nettype wire

// ### verification/ltfs_chk.sv
// port-level assertions for the letters tape feed-out sequencer
`timescale 1ns/100ps
`default_nettype none

module ltfs_chk (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic feed_request_i,
  input wire logic punch_strobe_o,
  input wire ltfs_pkg::ltfs_row_type punch_row_o,
  input wire logic tape_step_o,
  input wire logic slide_hold_o,
  input wire logic feed_busy_o,
  input wire logic recv_busy_o,
  input wire logic feed_lockout_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  // =====================================================
  // punch cycle
  a_strobe_steps:
    assert property (punch_strobe_o |-> tape_step_o && punch_row_o.feed_hole) else $error("strobe without step");
  a_row_settled:
    assert property (punch_strobe_o |-> $stable(punch_row_o)) else $error("row moved at strobe");
  a_strobe_single:
    assert property (punch_strobe_o |=> !punch_strobe_o) else $error("strobe longer than a clock");
  a_letters_code:
    assert property (punch_strobe_o && feed_busy_o |-> punch_row_o.code == 5'h1F) else $error("bad letters code");
  a_hold_around:
    assert property (punch_strobe_o |-> !slide_hold_o ##1 slide_hold_o) else $error("slide hold out of place");

  // =====================================================
  // request latching, lockout after acceptance only
  a_lockout_late:
    assert property ($rose(feed_busy_o) |-> !feed_lockout_o) else $error("lockout in accepting cycle");
  a_no_retrigger:
    assert property (feed_lockout_o |=> !$rose(feed_busy_o)) else $error("run started under lockout");
  a_lock_release:
    assert property ($fell(feed_lockout_o) |-> $past(feed_request_i, 2) == 1'b0) else $error("lockout dropped early");
  a_feed_or_recv:
    assert property (!(feed_busy_o && recv_busy_o)) else $error("feed and receive together");
endmodule // ltfs_chk

`default_nettype wire

// ### verification/ltfs_remote.sv
// remote pushbutton, line signal and shaft index model
`timescale 1ns/100ps
`default_nettype none

module ltfs_remote #(
  parameter int PERIOD = 16,
  parameter int QUIET = 40
) (
  input wire logic clock_i,
  input wire logic shaft_run_i,
  input wire logic press_i,
  input wire logic message_i,
  input wire logic idle_i,
  output logic shaft_index_o,
  output logic feed_request_o,
  output logic line_active_o
);
  int phase;
  int quiet;

  initial
  begin
    phase = 0;
    quiet = 0;
    shaft_index_o = 1'b0;
    feed_request_o = 1'b0;
    line_active_o = 1'b0;
  end

  // quiet stands in for the one second wait, shortened to keep runs brief
  always @(negedge clock_i)
  begin
    phase <= (phase == PERIOD - 1) ? 0 : phase + 1;
    shaft_index_o <= shaft_run_i && (phase < PERIOD / 2);
    line_active_o <= message_i;
    quiet <= message_i ? 0 : (quiet < QUIET ? quiet + 1 : quiet);
    feed_request_o <= press_i && (feed_request_o || (idle_i && quiet >= QUIET));
  end
endmodule // ltfs_remote

`default_nettype wire

// ### verification/tb_top.sv
// self-checking testbench for the letters tape feed-out sequencer
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  localparam int PERIOD = 16;
  logic clock_i, reset_n_i, shaft_run, press, message, char_valid;
  logic shaft_index, feed_request, line_active;
  logic [4:0] feed_length, char_code;
  logic char_ready_o, punch_strobe_o, tape_step_o, slide_hold_o, feed_busy_o, recv_busy_o, feed_lockout_o;
  ltfs_pkg::ltfs_row_type punch_row_o;
  ltfs_pkg::ltfs_row_type rows[$];
  int failures, num_checks, n, k, m;

  ltfs_top #(.SLIDE_CLEAR_CYCLES(2)) dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .shaft_index_i(shaft_index), .feed_request_i(feed_request), .line_active_i(line_active),
    .feed_length_i(feed_length), .char_valid_i(char_valid), .char_code_i(char_code),
    .char_ready_o(char_ready_o), .punch_strobe_o(punch_strobe_o), .punch_row_o(punch_row_o),
    .tape_step_o(tape_step_o), .slide_hold_o(slide_hold_o), .feed_busy_o(feed_busy_o),
    .recv_busy_o(recv_busy_o), .feed_lockout_o(feed_lockout_o));

  ltfs_remote #(.PERIOD(PERIOD), .QUIET(40)) u_remote (.clock_i(clock_i), .shaft_run_i(shaft_run),
    .press_i(press), .message_i(message), .idle_i(!feed_busy_o && !recv_busy_o),
    .shaft_index_o(shaft_index), .feed_request_o(feed_request), .line_active_o(line_active));

  initial
  begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  // taken mid-cycle, where the one-clock pulse has settled
  always @(negedge clock_i)
  begin
    if (punch_strobe_o === 1'b1)
      rows.push_back(punch_row_o);
  end

  // =====================================================
  // shared tasks
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // leaves valid high so back to back pushes never toggle it in one step
  task push(input logic [4:0] code);
    char_valid = 1'b1;
    char_code = code;
    for (m = 0; m < 200; m++)
    begin
      @(posedge clock_i);
      if (char_ready_o === 1'b1)
        break;
    end
    @(negedge clock_i);
  endtask

  // =====================================================
  // scenarios
  task t_feed(input logic [4:0] len);
    rows.delete();
    feed_length = len;
    press <= 1'b1;
    for (n = 0; n < 3000 && feed_busy_o !== 1'b1; n++) @(negedge clock_i);
    check("feed_busy", 8'h01, {7'h0, feed_busy_o});
    for (n = 0; n < 3000 && feed_busy_o !== 1'b0; n++) @(negedge clock_i);
    repeat (3 * PERIOD) @(negedge clock_i);
    check("busy_held_req", 8'h00, {7'h0, feed_busy_o});
    check("lockout_held", 8'h01, {7'h0, feed_lockout_o});
    check("letters_rows", 8'(6 * (int'(len) - 2)), 8'(rows.size()));
    foreach (rows[i]) check("letters_row", 8'h3F, {2'h0, rows[i]});
    press <= 1'b0;
    repeat (8) @(negedge clock_i);
    check("lockout_clear", 8'h00, {7'h0, feed_lockout_o});
    repeat (3 * PERIOD) @(negedge clock_i);
    check("idle_rows", 8'(6 * (int'(len) - 2)), 8'(rows.size()));
  endtask

  task t_abort;
    rows.delete();
    feed_length = 5'h06;
    press <= 1'b1;
    for (n = 0; n < 4000 && rows.size() < 3; n++) @(negedge clock_i);
    message <= 1'b1;
    k = rows.size();
    for (n = 0; n < 50 && recv_busy_o !== 1'b1; n++) @(negedge clock_i);
    check("feed_stopped", 8'h00, {7'h0, feed_busy_o});
    push(5'h05);
    push(5'h0A);
    push(5'h11);
    char_valid = 1'b0;
    repeat (6 * PERIOD) @(negedge clock_i);
    check("no_more_letters", 8'(k + 3), 8'(rows.size()));
    check("abort_row0", 8'h25, {2'h0, rows[rows.size() - 3]});
    check("abort_row1", 8'h2A, {2'h0, rows[rows.size() - 2]});
    check("abort_row2", 8'h31, {2'h0, rows[rows.size() - 1]});
    message <= 1'b0;
    press <= 1'b0;
    repeat (4 * PERIOD) @(negedge clock_i);
  endtask

  // shaft stopped so the buffer fills, then drained in order
  task t_fifo;
    rows.delete();
    message <= 1'b1;
    shaft_run <= 1'b0;
    repeat (2 * PERIOD) @(negedge clock_i);
    for (k = 0; k < 8; k++) push(5'(k));
    char_valid = 1'b0;
    @(negedge clock_i);
    check("fifo_full", 8'h00, {7'h0, char_ready_o});
    shaft_run <= 1'b1;
    push(5'h08);
    char_valid = 1'b0;
    for (n = 0; n < 20 * PERIOD && rows.size() < 9; n++) @(negedge clock_i);
    check("drained", 8'h09, 8'(rows.size()));
    for (k = 0; k < 9 && k < rows.size(); k++) check("fifo_row", 8'(8'h20 + k), {2'h0, rows[k]});
    message <= 1'b0;
  endtask

  initial
  begin
    failures = 0;
    num_checks = 0;
    reset_n_i = 1'b0;
    shaft_run = 1'b1;
    press = 1'b0;
    message = 1'b0;
    char_valid = 1'b0;
    char_code = 5'h00;
    feed_length = 5'h00;
    repeat (12) @(negedge clock_i);
    reset_n_i = 1'b1;
    repeat (4) @(negedge clock_i);
    t_feed(5'h02);
    t_feed(5'h03);
    t_abort();
    t_feed(5'h03);
    t_fifo();
    stop_test();
  end

  // the whole run needs a few thousand clocks
  initial
  begin
    #1000000;
    failures++;
    stop_test();
  end
endmodule // tb_top

bind ltfs_top ltfs_chk u_chk (.clock_i(clock_i), .reset_n_i(reset_n_i), .feed_request_i(feed_request_i),
  .punch_strobe_o(punch_strobe_o), .punch_row_o(punch_row_o), .tape_step_o(tape_step_o),
  .slide_hold_o(slide_hold_o), .feed_busy_o(feed_busy_o), .recv_busy_o(recv_busy_o),
  .feed_lockout_o(feed_lockout_o));

`default_nettype wire
